/* File: src/pdp_top.sv */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

// Behaviour
// - select code 00/01/10/11 divides system clock by 2/4/8/16 for input clock.
// - conversion period 16384..131072 clocks, minimum width 1..8 clocks per code.
// - clock select bits are write-only and always read back as one.
// - control bits 7..2 stay one; control register resets to 0xfc.
// - duty is upper register bits 5..0 above the eight lower bits.
// - writing upper register latches duty; generator takes it at period boundary.
// - both duty registers are write-only and read as all ones.
// - duty registers reset to 0xc0 upper and 0x00 lower.
// - each conversion period is 64 pulses on the single output.
// - summed high time per period equals duty plus 64 minimum widths, at most 16384 (full high).
// - standby release bit zero stops the block, one (reset) runs it.
// - registers reset by reset, held in low-power modes and module standby.
module pdp_top (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic [15:0] ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	input  wire logic        LOW_POWER,
	output logic             PWM_OUT,
	output logic             PWM_STANDBY
);

	// ==================================================
	// functions

	// bit reversal spreads the extra steps over the period
	function automatic logic [pdp_pkg::PULSE_IDX_W-1:0] bitrev6(
		input logic [pdp_pkg::PULSE_IDX_W-1:0] v
	);
		logic [pdp_pkg::PULSE_IDX_W-1:0] r;
		r = '0;
		for (int i = 0; i < pdp_pkg::PULSE_IDX_W; i++) begin
			r[i] = v[pdp_pkg::PULSE_IDX_W-1-i];
		end
		return r;
	endfunction

	function automatic logic hit(
		input logic [15:0] a,
		input logic [15:0] target
	);
		return a == target;
	endfunction

	// ==================================================
	// declarations
	logic [pdp_pkg::SEL_W-1:0]        clock_sel;
	logic [pdp_pkg::UPPER_DUTY_W-1:0] duty_upper;
	logic [pdp_pkg::LOWER_DUTY_W-1:0] duty_lower;
	logic [pdp_pkg::DUTY_W-1:0]       duty_latched;
	logic [1:0]                       upper_fixed;
	logic [pdp_pkg::GATE_STORE_W-1:0] clock_gate;
	logic                             load_pending;
	logic                             wr_ok;
	logic                             wr_upper;
	pdp_pkg::pdp_cfg_t                cfg_reg;
	pdp_pkg::pdp_cfg_t                cfg_act;
	pdp_pkg::pdp_state_t              state;
	pdp_pkg::pdp_state_t              next_state;
	logic                             released;
	logic                             running;
	logic                             tick;
	logic [pdp_pkg::SLOT_W-1:0]       slot;
	logic [pdp_pkg::PULSE_IDX_W-1:0]  pulse;
	logic                             period_end;
	logic                             extra;
	logic [pdp_pkg::SLOT_W:0]         width;
	logic                             level;
	logic [7:0]                       next_rdata;

	// ==================================================
	// write qualification

	// low-power modes freeze the register contents
	assign wr_ok    = WR && !LOW_POWER;
	assign wr_upper = wr_ok && hit(ADDR, pdp_pkg::ADDR_DUTY_UPPER);

	// ==================================================
	// clock select register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			clock_sel <= pdp_pkg::RST_CLOCK_SELECT[pdp_pkg::SEL_LSB +: pdp_pkg::SEL_W];
		end else if (wr_ok && hit(ADDR, pdp_pkg::ADDR_CLOCK_SELECT)) begin
			// bits 7..2 have no storage at all
			clock_sel <= WDATA[pdp_pkg::SEL_LSB +: pdp_pkg::SEL_W];
		end
	end

	// ==================================================
	// duty registers
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			duty_upper <= pdp_pkg::RST_DUTY_UPPER[pdp_pkg::UPPER_DUTY_W-1:0];
		end else if (wr_upper) begin
			// top two bits are fixed ones, not stored
			duty_upper <= WDATA[pdp_pkg::UPPER_DUTY_W-1:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			duty_lower <= pdp_pkg::RST_DUTY_LOWER;
		end else if (wr_ok && hit(ADDR, pdp_pkg::ADDR_DUTY_LOWER)) begin
			duty_lower <= WDATA;
		end
	end

	// ==================================================
	// clock gate register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			clock_gate <= pdp_pkg::RST_CLOCK_GATE[pdp_pkg::GATE_STORE_W-1:0];
		end else if (wr_ok && hit(ADDR, pdp_pkg::ADDR_CLOCK_GATE)) begin
			clock_gate <= WDATA[pdp_pkg::GATE_STORE_W-1:0];
		end
	end

	assign released    = clock_gate[pdp_pkg::GATE_RELEASE_BIT];
	assign PWM_STANDBY = !released;

	// ==================================================
	// latch of the full value on the upper write

	// lower byte must already hold the new value here
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			duty_latched <= {pdp_pkg::RST_DUTY_UPPER[pdp_pkg::UPPER_DUTY_W-1:0],
			                 pdp_pkg::RST_DUTY_LOWER};
		end else if (wr_upper) begin
			duty_latched <= {WDATA[pdp_pkg::UPPER_DUTY_W-1:0], duty_lower};
		end
	end

	// one driver for the staged pair; period change also waits for the boundary
	assign cfg_reg = '{sel: clock_sel, duty: duty_latched};

	// new write in the take-over cycle keeps the flag set
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			load_pending <= 1'b0;
		end else if (wr_upper) begin
			load_pending <= 1'b1;
		end else if (period_end || state == pdp_pkg::PDP_ST_STOP) begin
			load_pending <= 1'b0;
		end
	end

	// ==================================================
	// active configuration

	// switching mid-period would tear a pulse, so wait for the boundary
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			cfg_act.sel  <= pdp_pkg::RST_CLOCK_SELECT[pdp_pkg::SEL_LSB +: pdp_pkg::SEL_W];
			cfg_act.duty <= {pdp_pkg::RST_DUTY_UPPER[pdp_pkg::UPPER_DUTY_W-1:0],
			                 pdp_pkg::RST_DUTY_LOWER};
		end else if (period_end || state == pdp_pkg::PDP_ST_STOP) begin
			cfg_act <= cfg_reg;
		end
	end

	// ==================================================
	// operating state
	always_comb begin
		next_state = state;
		unique case (state)
			pdp_pkg::PDP_ST_STOP: begin
				if (released && !LOW_POWER) begin
					next_state = pdp_pkg::PDP_ST_RUN;
				end
			end
			pdp_pkg::PDP_ST_RUN: begin
				if (!released) begin
					next_state = pdp_pkg::PDP_ST_STOP;
				end else if (LOW_POWER) begin
					next_state = pdp_pkg::PDP_ST_HOLD;
				end
			end
			pdp_pkg::PDP_ST_HOLD: begin
				if (!released) begin
					next_state = pdp_pkg::PDP_ST_STOP;
				end else if (!LOW_POWER) begin
					next_state = pdp_pkg::PDP_ST_RUN;
				end
			end
			default: begin
				next_state = pdp_pkg::PDP_ST_STOP;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state <= pdp_pkg::PDP_ST_STOP;
		end else begin
			state <= next_state;
		end
	end

	assign running = (state == pdp_pkg::PDP_ST_RUN) && !LOW_POWER && released;

	// ==================================================
	// unit tick
	pdp_prescale pdp_prescale_inst (
		.clk  (CORE_CLK),
		.rst  (RST),
		.run  (running),
		.sel  (cfg_act.sel),
		.tick (tick)
	);

	// ==================================================
	// slot and pulse counters

	// 256 units per pulse, 64 pulses per period
	assign period_end = tick && (slot == pdp_pkg::SLOT_W'(pdp_pkg::SLOTS_PER_PULSE - 1))
	                    && (pulse == pdp_pkg::PULSE_IDX_W'(pdp_pkg::PULSE_COUNT - 1));

	always_ff @(posedge CORE_CLK) begin
		if (RST || state == pdp_pkg::PDP_ST_STOP) begin
			slot <= '0;
		end else if (tick) begin
			slot <= slot + 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST || state == pdp_pkg::PDP_ST_STOP) begin
			pulse <= '0;
		end else if (tick && slot == pdp_pkg::SLOT_W'(pdp_pkg::SLOTS_PER_PULSE - 1)) begin
			pulse <= pulse + 1'b1;
		end
	end

	// ==================================================
	// pulse width

	// one base unit plus the upper duty bits, plus one spread step
	assign extra = bitrev6(pulse) < cfg_act.duty[pdp_pkg::PULSE_IDX_W-1:0];
	assign width = (pdp_pkg::SLOT_W+1)'(cfg_act.duty[pdp_pkg::DUTY_W-1:pdp_pkg::PULSE_IDX_W])
	               + (pdp_pkg::SLOT_W+1)'(1) + (pdp_pkg::SLOT_W+1)'(extra);

	// widths above 256 saturate at a fully high pulse
	assign level = {1'b0, slot} < width;

	always_ff @(posedge CORE_CLK) begin
		if (RST || state == pdp_pkg::PDP_ST_STOP) begin
			PWM_OUT <= 1'b0;
		end else if (running) begin
			PWM_OUT <= level;
		end
	end

	// ==================================================
	// read data
	always_comb begin
		next_rdata = '0;
		if (RD) begin
			if (hit(ADDR, pdp_pkg::ADDR_CLOCK_SELECT)) begin
				next_rdata = pdp_pkg::READ_ALL_ONES;
			end else if (hit(ADDR, pdp_pkg::ADDR_DUTY_UPPER)) begin
				next_rdata = {upper_fixed, pdp_pkg::READ_ALL_ONES[pdp_pkg::UPPER_DUTY_W-1:0]};
			end else if (hit(ADDR, pdp_pkg::ADDR_DUTY_LOWER)) begin
				next_rdata = pdp_pkg::READ_ALL_ONES;
			end else if (hit(ADDR, pdp_pkg::ADDR_CLOCK_GATE)) begin
				next_rdata = {pdp_pkg::GATE_RSVD_ONES, clock_gate};
			end else if (hit(ADDR, pdp_pkg::ADDR_STATUS)) begin
				next_rdata[pdp_pkg::STAT_PENDING_BIT] = load_pending;
				next_rdata[pdp_pkg::STAT_LEVEL_BIT]   = PWM_OUT;
				next_rdata[pdp_pkg::STAT_PULSE_LSB +: pdp_pkg::PULSE_IDX_W] = pulse;
			end else begin
				next_rdata = pdp_pkg::READ_UNMAPPED;
			end
		end
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			RDATA <= '0;
		end else begin
			RDATA <= next_rdata;
		end
	end

	// upper register fixed bits exist only as read-back ones
	assign upper_fixed = pdp_pkg::UPPER_RSVD_ONES;

endmodule // pdp_top

/* File: include/pdp_pkg.sv */
package pdp_pkg;

	// ==================================================
	// register map
	localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hffd0;
	localparam logic [15:0] ADDR_DUTY_UPPER   = 16'hffd1;
	localparam logic [15:0] ADDR_DUTY_LOWER   = 16'hffd2;
	localparam logic [15:0] ADDR_STATUS       = 16'hffd3;
	localparam logic [15:0] ADDR_CLOCK_GATE   = 16'hfffb;

	// ==================================================
	// reset values
	localparam logic [7:0] RST_CLOCK_SELECT = 8'hfc;
	localparam logic [7:0] RST_DUTY_UPPER   = 8'hc0;
	localparam logic [7:0] RST_DUTY_LOWER   = 8'h00;
	localparam logic [7:0] RST_CLOCK_GATE   = 8'hff;

	// ==================================================
	// read-back values
	localparam logic [7:0] READ_ALL_ONES = 8'hff;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [3:0] GATE_RSVD_ONES = 4'hf;
	localparam logic [1:0] UPPER_RSVD_ONES = 2'h3;

	// ==================================================
	// field positions
	localparam int SEL_LSB         = 0;
	localparam int SEL_W           = 2;
	localparam int UPPER_DUTY_W    = 6;
	localparam int LOWER_DUTY_W    = 8;
	localparam int GATE_STORE_W    = 4;
	localparam int GATE_RELEASE_BIT = 1;
	localparam int STAT_PENDING_BIT = 0;
	localparam int STAT_LEVEL_BIT  = 1;
	localparam int STAT_PULSE_LSB  = 2;

	// ==================================================
	// waveform timing counts
	localparam int DUTY_W        = UPPER_DUTY_W + LOWER_DUTY_W;
	localparam int PULSE_IDX_W   = 6;
	localparam int PULSE_COUNT   = 64;
	localparam int SLOT_W        = 8;
	localparam int SLOTS_PER_PULSE = 256;
	localparam int PERIOD_UNITS  = PULSE_COUNT * SLOTS_PER_PULSE;
	localparam int PRESC_W       = 4;
	localparam int DIV_MIN       = 2;

	// ==================================================
	// types
	typedef enum logic [1:0] {
		PDP_ST_STOP = 2'b00,
		PDP_ST_RUN  = 2'b01,
		PDP_ST_HOLD = 2'b11
	} pdp_state_t;

	typedef struct packed {
		logic [SEL_W-1:0]  sel;
		logic [DUTY_W-1:0] duty;
	} pdp_cfg_t;

endpackage

/* File: src/pdp_prescale.sv */
`timescale 1ns/10ps

// unit tick generator: one tick per minimum modulation width
module pdp_prescale (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          run,
	input  wire logic [pdp_pkg::SEL_W-1:0]     sel,
	output logic                               tick
);

	// ==================================================
	// divider
	logic [pdp_pkg::PRESC_W-1:0] count;
	logic [pdp_pkg::PRESC_W-1:0] last;

	// half the input clock: phi/2 -> 1, phi/16 -> 8 core clocks
	assign last = pdp_pkg::PRESC_W'((1 << sel) - 1);

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
		end else if (!run || count == last) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// combinational so the slot counter moves on the same edge
	assign tick = run && (count == last);

endmodule // pdp_prescale

/* File: tb/pdp_top_props.sv */
`timescale 1ns/10ps

module pdp_props (
	input wire logic        CORE_CLK,
	input wire logic        RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [7:0]  RDATA,
	input wire logic        LOW_POWER,
	input wire logic        PWM_OUT,
	input wire logic        PWM_STANDBY
);
	// ==================================================
	// helper: low run while running, 255 units of 8 clocks plus slack
	logic [11:0] low_run;

	always_ff @(posedge CORE_CLK) begin
		if (RST || PWM_OUT || PWM_STANDBY || LOW_POWER) begin
			low_run <= 12'h000;
		end else begin
			low_run <= low_run + 12'h001;
		end
	end

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	// ==================================================
	// sequences and properties
	sequence s_read(logic [15:0] a);
		RD && ADDR == a;
	endsequence
	sequence s_gate_write;
		WR && ADDR == 16'hfffb;
	endsequence

	property p_sel_reads; s_read(16'hffd0) |=> RDATA == 8'hff; endproperty
	property p_upper_reads; s_read(16'hffd1) |=> RDATA == 8'hff; endproperty
	property p_lower_reads; s_read(16'hffd2) |=> RDATA == 8'hff; endproperty
	property p_gate_reads; s_read(16'hfffb) |=> RDATA[7:4] == 4'hf; endproperty
	property p_rdata_idle; !RD |=> RDATA == 8'h00; endproperty
	property p_stop_quiet; PWM_STANDBY [*3] |-> !PWM_OUT; endproperty
	property p_hold_freeze; LOW_POWER [*4] |-> $stable(PWM_OUT); endproperty
	property p_pulse_gap; low_run < 12'd2100; endproperty
	property p_standby_enter; s_gate_write ##0 !WDATA[1] && !LOW_POWER |=> PWM_STANDBY; endproperty
	property p_lp_refuse; s_gate_write ##0 LOW_POWER && !PWM_STANDBY |=> !PWM_STANDBY; endproperty

	a_sel_reads: assert property (p_sel_reads) else $error("select read not ones");
	a_upper_reads: assert property (p_upper_reads) else $error("upper read not ones");
	a_lower_reads: assert property (p_lower_reads) else $error("lower read not ones");
	a_gate_reads: assert property (p_gate_reads) else $error("gate top bits not ones");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	a_stop_quiet: assert property (p_stop_quiet) else $error("output active in standby");
	a_hold_freeze: assert property (p_hold_freeze) else $error("output moved in low power");
	a_pulse_gap: assert property (p_pulse_gap) else $error("pulse missing");
	a_standby_enter: assert property (p_standby_enter) else $error("standby not entered");
	a_lp_refuse: assert property (p_lp_refuse) else $error("write taken in low power");
endmodule // pdp_props

bind pdp_top pdp_props pdp_props_inst (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.RD(RD), .RDATA(RDATA), .LOW_POWER(LOW_POWER), .PWM_OUT(PWM_OUT), .PWM_STANDBY(PWM_STANDBY));

/* File: tb/pdp_lpf.sv */
`timescale 1ns/10ps

// ==================================================
// integrating filter: high-time sum and high-run extremes
module pdp_lpf (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        pwm,
	input  wire logic        clr,
	output logic      [31:0] hi_sum,
	output logic      [15:0] min_run,
	output logic      [15:0] max_run
);
	logic [15:0] run;
	logic        pwm_d;

	// window must open in a low part, else the first run is partial
	always_ff @(posedge clk) begin
		if (rst || clr) begin
			hi_sum  <= 32'h0;
			run     <= 16'h0;
			min_run <= 16'hffff;
			max_run <= 16'h0;
			pwm_d   <= 1'b0;
		end else begin
			hi_sum <= hi_sum + {31'h0, pwm};
			run    <= pwm ? run + 16'h1 : 16'h0;
			pwm_d  <= pwm;
			if (pwm_d && !pwm) begin
				min_run <= (run < min_run) ? run : min_run;
				max_run <= (run > max_run) ? run : max_run;
			end
		end
	end
endmodule // pdp_lpf

/* File: tb/tb_pdp_top.sv */
`timescale 1ns/10ps

module tb_pdp_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] addr = 16'h0;
	logic [7:0]  wdata = 8'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        low_power = 1'b0;
	logic        clr = 1'b0;
	logic [7:0]  rdata;
	logic        pwm;
	logic        stby;
	logic [31:0] hi_sum;
	logic [15:0] min_run;
	logic [15:0] max_run;
	int          bad_count = 0;
	int          n_tests = 0;

	always #5 clk = ~clk;

	pdp_top pdp_top_inst (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .LOW_POWER(low_power), .PWM_OUT(pwm), .PWM_STANDBY(stby));
	pdp_lpf pdp_lpf_inst (.clk(clk), .rst(rst), .pwm(pwm), .clr(clr), .hi_sum(hi_sum),
		.min_run(min_run), .max_run(max_run));

	// ==================================================
	// bus and compare helpers
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_val(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd_val(a, v);
		chk(name, {24'h0, exp}, {24'h0, v});
	endtask

	task automatic wait_pwm(input logic lvl, output int n);
		n = 0;
		while (pwm !== lvl && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic window(input int pre);
		repeat (pre) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (16384) @(posedge clk);
		#1;
	endtask

	// ==================================================
	// scenarios
	task automatic t_reset_values();
		int h;
		int p;
		rd_chk("select", 16'hffd0, 8'hff);
		rd_chk("upper", 16'hffd1, 8'hff);
		rd_chk("lower", 16'hffd2, 8'hff);
		rd_chk("gate", 16'hfffb, 8'hff);
		rd_chk("unmapped", 16'hffd8, 8'h00);
		chk("standby", 32'h0, {31'h0, stby});
		wait_pwm(1'b1, h);
		wait_pwm(1'b0, h);
		wait_pwm(1'b1, p);
		chk("reset high", 32'd1, 32'(h));
		chk("reset pulse", 32'd256, 32'(h + p));
	endtask

	task automatic t_select(input logic [1:0] sel);
		int h;
		int p;
		wr_reg(16'hfffb, 8'hfd);
		#1;
		chk("standby", 32'h1, {31'h0, stby});
		rd_chk("gate", 16'hfffb, 8'hfd);
		wr_reg(16'hffd0, {6'h00, sel});
		wr_reg(16'hffd2, 8'h00);
		wr_reg(16'hffd1, 8'hc1);
		wr_reg(16'hfffb, 8'hff);
		wait_pwm(1'b1, h);
		wait_pwm(1'b0, h);
		wait_pwm(1'b1, p);
		chk("high", 32'd5 << sel, 32'(h));
		chk("pulse", 32'd256 << sel, 32'(h + p));
	endtask

	task automatic t_period();
		logic [7:0] v;
		wr_reg(16'hfffb, 8'hfd);
		wr_reg(16'hffd0, 8'h00);
		wr_reg(16'hffd2, 8'h05);
		wr_reg(16'hffd1, 8'h10);
		wr_reg(16'hfffb, 8'hff);
		window(100);
		chk("sum", 32'h1005 + 32'd64, hi_sum);
		chk("min run", 32'd65, {16'h0, min_run});
		chk("max run", 32'd66, {16'h0, max_run});
		wr_reg(16'hffd2, 8'hff);
		window(16500);
		chk("sum kept", 32'h1005 + 32'd64, hi_sum);
		wr_reg(16'hffd1, 8'h10);
		rd_val(16'hffd3, v);
		chk("pending", 32'h1, {31'h0, v[0]});
	endtask

	task automatic t_low_power();
		@(posedge clk);
		low_power <= 1'b1;
		wr_reg(16'hfffb, 8'hfd);
		rd_chk("gate held", 16'hfffb, 8'hff);
		chk("standby held", 32'h0, {31'h0, stby});
		@(posedge clk);
		low_power <= 1'b0;
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==================================================
	// main sequence and watchdog
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
		for (int s = 0; s < 4; s++) begin
			t_select(2'(s));
		end
		t_period();
		t_low_power();
		report_and_stop();
	end

	initial begin
		repeat (80000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule // tb_pdp_top
